/* common/lcsc_map.vh */
// Register indices, field positions, reset values and scale codes for the LED current control block.
`ifndef LCSC_MAP_VH
`define LCSC_MAP_VH

// Register indices; the byte address on the bus is four times the index.
`define LCSC_IDX_SHUTDOWN 8'h00
`define LCSC_IDX_LED_FIRST 8'h2A
`define LCSC_IDX_LED_LAST 8'h45
`define LCSC_IDX_STATUS 8'h50

// Address slicing of the byte address into a word index.
`define LCSC_ADR_IDX_MSB 9
`define LCSC_ADR_IDX_LSB 2

// Shutdown register layout.
`define LCSC_SSD_BIT 0
`define LCSC_SHUTDOWN_RST 1'b0

// Per-channel control register layout.
`define LCSC_LED_ON_BIT 0
`define LCSC_SCALE_LSB 1
`define LCSC_SCALE_MSB 2
`define LCSC_LED_CTRL_W 3
`define LCSC_LED_CTRL_RST 3'h0

// Status register layout.
`define LCSC_STAT_SLEEP_BIT 0
`define LCSC_STAT_PIN_BIT 1
`define LCSC_STAT_SSD_BIT 2

// Current scale codes and their divisors of the peak sink current.
`define LCSC_SCALE_FULL 2'h0
`define LCSC_SCALE_HALF 2'h1
`define LCSC_SCALE_THIRD 2'h2
`define LCSC_SCALE_QUARTER 2'h3
`define LCSC_DIV_FULL 3'h1
`define LCSC_DIV_HALF 3'h2
`define LCSC_DIV_THIRD 3'h3
`define LCSC_DIV_QUARTER 3'h4

// Bus constants.
`define LCSC_DATA_ZERO 32'h0000_0000

`endif

/* logic/lcsc_chan_bank.v */
// Per-channel control register bank with a registered read port.
`timescale 1ns/1ps
`default_nettype none
`include "lcsc_map.vh"

module lcsc_chan_bank #(
	parameter CHANS = 28,
	parameter IW = 5
) (
	input wire clk_i,
	input wire rst_i,
	input wire wr_en_i,
	input wire [IW-1:0] wr_chan_i,
	input wire [`LCSC_LED_CTRL_W-1:0] wr_data_i,
	input wire [IW-1:0] rd_chan_i,
	output reg [`LCSC_LED_CTRL_W-1:0] rd_data_o,
	output wire [`LCSC_LED_CTRL_W*CHANS-1:0] fields_o
);

reg [`LCSC_LED_CTRL_W*CHANS-1:0] fields;

////////////////////////////////////////////////////////////////////////////////
// Storage is flops, not RAM, because every channel field drives its sink at once.
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		fields <= {CHANS{`LCSC_LED_CTRL_RST}};
		rd_data_o <= `LCSC_LED_CTRL_RST;
	end
	else
	begin
		if (wr_en_i)
		begin
			fields[wr_chan_i*`LCSC_LED_CTRL_W +: `LCSC_LED_CTRL_W] <= wr_data_i;
		end
		rd_data_o <= fields[rd_chan_i*`LCSC_LED_CTRL_W +: `LCSC_LED_CTRL_W];
	end
end

assign fields_o = fields;

endmodule // lcsc_chan_bank
`default_nettype wire

/* logic/lcsc_out_stage.v */
// Output stage that gates channel enables by shutdown and decodes the current scale.
`timescale 1ns/1ps
`default_nettype none
`include "lcsc_map.vh"

module lcsc_out_stage #(
	parameter CHANS = 28
) (
	input wire clk_i,
	input wire rst_i,
	input wire [`LCSC_LED_CTRL_W*CHANS-1:0] fields_i,
	input wire sleep_i,
	output reg [CHANS-1:0] led_on_o,
	output reg [2*CHANS-1:0] scale_sel_o,
	output reg [3*CHANS-1:0] scale_div_o
);

integer ch;
reg [CHANS-1:0] next_led_on;
reg [2*CHANS-1:0] next_scale_sel;
reg [3*CHANS-1:0] next_scale_div;
reg [`LCSC_LED_CTRL_W-1:0] fld;

// Map a scale code to the divisor of the peak sink current.
function [2:0] scale_divisor;
	input [1:0] code;
	begin
		case (code)
			`LCSC_SCALE_FULL: scale_divisor = `LCSC_DIV_FULL;
			`LCSC_SCALE_HALF: scale_divisor = `LCSC_DIV_HALF;
			`LCSC_SCALE_THIRD: scale_divisor = `LCSC_DIV_THIRD;
			default: scale_divisor = `LCSC_DIV_QUARTER;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Next output values; the scale stays visible in sleep so the analog side settles early.
always @*
begin
	fld = `LCSC_LED_CTRL_RST;
	next_led_on = {CHANS{1'b0}};
	next_scale_sel = {2*CHANS{1'b0}};
	next_scale_div = {3*CHANS{1'b0}};
	for (ch = 0; ch < CHANS; ch = ch + 1)
	begin
		fld = fields_i[ch*`LCSC_LED_CTRL_W +: `LCSC_LED_CTRL_W];
		next_led_on[ch] = fld[`LCSC_LED_ON_BIT] & ~sleep_i;
		next_scale_sel[ch*2 +: 2] = fld[`LCSC_SCALE_MSB:`LCSC_SCALE_LSB];
		next_scale_div[ch*3 +: 3] = scale_divisor(fld[`LCSC_SCALE_MSB:`LCSC_SCALE_LSB]);
	end
end

// Outputs leave on flops so the sink drivers see glitch-free levels.
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		led_on_o <= {CHANS{1'b0}};
		scale_sel_o <= {2*CHANS{1'b0}};
		scale_div_o <= {CHANS{`LCSC_DIV_FULL}};
	end
	else
	begin
		led_on_o <= next_led_on;
		scale_sel_o <= next_scale_sel;
		scale_div_o <= next_scale_div;
	end
end

endmodule // lcsc_out_stage
`default_nettype wire

/* logic/lcsc_ctrl.v */
// Top level: Wishbone register slave, shutdown control and per-channel current scaling.
`timescale 1ns/1ps
`default_nettype none
`include "lcsc_map.vh"

module lcsc_ctrl #(
	parameter CHANS = 28
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [9:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire hw_sleep_pin_n_i,
	output wire [CHANS-1:0] led_sink_outputs_on_o,
	output wire [2*CHANS-1:0] current_scale_sel_o,
	output wire [3*CHANS-1:0] led_scale_div_o,
	output reg sleep_active_o
);

localparam IW = 5;

wire [7:0] idx;
wire req;
wire wr_fire;
wire [IW-1:0] chan;
wire [`LCSC_LED_CTRL_W-1:0] bank_rd;
wire [`LCSC_LED_CTRL_W*CHANS-1:0] fields;
wire sleep_now;
reg soft_sleep_bit;
reg phase;
reg [31:0] next_dat;

////////////////////////////////////////////////////////////////////////////////
// True when the index falls in the per-channel control window.
function is_led_idx;
	input [7:0] i;
	begin
		is_led_idx = (i >= `LCSC_IDX_LED_FIRST) && (i <= `LCSC_IDX_LED_LAST);
	end
endfunction

// Channel number of a control register index, cut to the bank index width.
function [IW-1:0] chan_of;
	input [7:0] i;
	reg [7:0] d;
	begin
		d = i - `LCSC_IDX_LED_FIRST;
		chan_of = d[IW-1:0];
	end
endfunction

assign idx = wb_adr_i[`LCSC_ADR_IDX_MSB:`LCSC_ADR_IDX_LSB];
assign req = wb_cyc_i & wb_stb_i;
// Writes land only at the edge where the master samples ack, and need lane 0.
assign wr_fire = req & wb_we_i & wb_ack_o & wb_sel_i[0];
assign chan = is_led_idx(idx) ? chan_of(idx) : {IW{1'b0}};

////////////////////////////////////////////////////////////////////////////////
// Two-stage answer: the bank read needs one cycle before data is muxed out.
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		phase <= 1'b0;
		wb_ack_o <= 1'b0;
	end
	else
	begin
		phase <= req & ~phase & ~wb_ack_o;
		wb_ack_o <= phase & req;
	end
end

// Soft sleep register; shutdown itself never writes it or any other register.
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		soft_sleep_bit <= `LCSC_SHUTDOWN_RST;
	end
	else if (wr_fire && idx == `LCSC_IDX_SHUTDOWN)
	begin
		soft_sleep_bit <= wb_dat_i[`LCSC_SSD_BIT];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Channel control registers; unmapped writes are acknowledged and dropped.
// channel register bank.
lcsc_chan_bank #(
	.CHANS(CHANS),
	.IW(IW)
) u_bank (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wr_en_i(wr_fire & is_led_idx(idx)),
	.wr_chan_i(chan),
	.wr_data_i(wb_dat_i[`LCSC_LED_CTRL_W-1:0]),
	.rd_chan_i(chan),
	.rd_data_o(bank_rd),
	.fields_o(fields)
);

////////////////////////////////////////////////////////////////////////////////
// soft sleep at zero.
assign sleep_now = ~soft_sleep_bit | ~hw_sleep_pin_n_i;

// Read mux; unmapped indices and reserved bits read as zero.
always @*
begin
	next_dat = `LCSC_DATA_ZERO;
	if (idx == `LCSC_IDX_SHUTDOWN)
	begin
		next_dat[`LCSC_SSD_BIT] = soft_sleep_bit;
	end
	else if (is_led_idx(idx))
	begin
		next_dat[`LCSC_LED_CTRL_W-1:0] = bank_rd;
	end
	else if (idx == `LCSC_IDX_STATUS)
	begin
		next_dat[`LCSC_STAT_SLEEP_BIT] = sleep_now;
		next_dat[`LCSC_STAT_PIN_BIT] = hw_sleep_pin_n_i;
		next_dat[`LCSC_STAT_SSD_BIT] = soft_sleep_bit;
	end
end

// Read data and sleep status are registered so every top output leaves a flop.
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		wb_dat_o <= `LCSC_DATA_ZERO;
		sleep_active_o <= 1'b1;
	end
	else
	begin
		wb_dat_o <= (phase & req & ~wb_we_i) ? next_dat : `LCSC_DATA_ZERO;
		sleep_active_o <= sleep_now;
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs forced off.
lcsc_out_stage #(
	.CHANS(CHANS)
) u_out (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.fields_i(fields),
	.sleep_i(sleep_now),
	.led_on_o(led_sink_outputs_on_o),
	.scale_sel_o(current_scale_sel_o),
	.scale_div_o(led_scale_div_o)
);

endmodule // lcsc_ctrl
`default_nettype wire

/* testbench/lcsc_ctrl_checker.sv */
// Concurrent checks on the LED current control top level.
`timescale 1ns/1ps
`default_nettype none
module lcsc_ctrl_checker #(
	parameter CHANS = 28
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic hw_sleep_pin_n_i,
	input wire logic [CHANS-1:0] led_sink_outputs_on_o,
	input wire logic [2*CHANS-1:0] current_scale_sel_o,
	input wire logic [3*CHANS-1:0] led_scale_div_o,
	input wire logic sleep_active_o
);
	// One clock domain, so clocking and reset are given once.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_latency_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> !wb_ack_o ##1 wb_ack_o)
		else $error("ack not two cycles after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data outside ack");
	reserved_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:3] == 29'h0000_0000)
		else $error("reserved bits not zero");
	sleep_dark_a: assert property (sleep_active_o |-> led_sink_outputs_on_o == '0)
		else $error("channel on in shutdown");
	pin_sleep_a: assert property (!hw_sleep_pin_n_i |=> sleep_active_o && led_sink_outputs_on_o == '0)
		else $error("pin low without shutdown");
	pin_gate_a: assert property (|led_sink_outputs_on_o |-> $past(hw_sleep_pin_n_i))
		else $error("channel on after pin low");
	scale_decode_a: assert property (led_scale_div_o[2:0] == {1'b0, current_scale_sel_o[1:0]} + 3'h1
		&& led_scale_div_o[3*CHANS-1 -: 3] == {1'b0, current_scale_sel_o[2*CHANS-1 -: 2]} + 3'h1)
		else $error("scale divisor wrong");
	scale_hold_a: assert property (!wb_cyc_i [*3] |-> $stable(current_scale_sel_o))
		else $error("scale changed without write");
	// Main scenarios.
	cover property (wb_ack_o && wb_we_i);
	cover property (!hw_sleep_pin_n_i ##1 sleep_active_o);
	cover property (|led_sink_outputs_on_o);
endmodule // lcsc_ctrl_checker
bind lcsc_ctrl lcsc_ctrl_checker #(.CHANS(CHANS)) chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .hw_sleep_pin_n_i, .led_sink_outputs_on_o,
	.current_scale_sel_o, .led_scale_div_o, .sleep_active_o);
`default_nettype wire

/* testbench/lcsc_host.sv */
// Host model that issues classic Wishbone register cycles.
`timescale 1ns/1ps
`default_nettype none
module lcsc_host (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic we_o,
	output logic [9:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	// Idle bus at time zero.
	initial {cyc_o, we_o, adr_o, sel_o, dat_o} = '0;
	// ascending 32-step ramp.
	// Step 0 sits in the low byte, so a step number indexes the ramp directly.
	localparam logic [255:0] duty_ramp = {8'hFF, 8'hF0, 8'hE2, 8'hD4, 8'hC7, 8'hBA, 8'hAD, 8'hA1,
		8'h95, 8'h8A, 8'h7E, 8'h74, 8'h6A, 8'h60, 8'h56, 8'h4E, 8'h45, 8'h3D, 8'h35, 8'h2E, 8'h27, 8'h21,
		8'h1C, 8'h16, 8'h12, 8'h0D, 8'h0A, 8'h06, 8'h04, 8'h02, 8'h01, 8'h00};
	function automatic logic [7:0] ramp_step(input int k);
		return duty_ramp[k*8 +: 8];
	endfunction
	// Hold the request until ack; on release we, address and data are inverted so stale values never match.
	task xfer(input logic w, input logic [7:0] i, input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
		begin
			cyc_o <= 1'b1;
			we_o <= w;
			adr_o <= {i, 2'b00};
			sel_o <= s;
			dat_o <= d;
			@(posedge clk_i);
			while (ack_i !== 1'b1)
				@(posedge clk_i);
			q = dat_i;
			cyc_o <= 1'b0;
			we_o <= ~w;
			adr_o <= ~{i, 2'b00};
			dat_o <= ~d;
			@(posedge clk_i);
		end
	endtask
endmodule // lcsc_host
`default_nettype wire

/* testbench/lcsc_ctrl_tb.sv */
// Register-level test of the LED current control block.
`timescale 1ns/1ps
`default_nettype none
module lcsc_ctrl_tb;
	logic clk_i, rst_i, pin_n, cyc, we, ack, sleep;
	logic [9:0] adr;
	logic [3:0] sel;
	logic [31:0] wd, rd, q;
	logic [27:0] led;
	logic [55:0] ssel;
	logic [83:0] div;
	int errors, compares, cycles;
	lcsc_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc), .we_o(we), .adr_o(adr),
		.sel_o(sel), .dat_o(wd));
	lcsc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.hw_sleep_pin_n_i(pin_n), .led_sink_outputs_on_o(led), .current_scale_sel_o(ssel),
		.led_scale_div_o(div), .sleep_active_o(sleep));
	// 8 ns clock.
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] i, input logic [31:0] d);
		host.xfer(1'b1, i, 4'h1, d, q);
	endtask
	task rdc(input logic [7:0] i, input logic [31:0] e, input string n);
		host.xfer(1'b0, i, 4'hF, 32'h0000_0000, q);
		chk(n, e, q);
	endtask
	// Outputs follow one edge after their source; three edges leave margin.
	task settle;
		repeat (3) @(posedge clk_i);
	endtask
	task end_of_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// A hang is cut short well past the expected run length.
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			end_of_test;
		end
	end
	initial
	begin
		rst_i = 1'b1;
		pin_n = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("sleep", 32'h0000_0001, sleep);
		rdc(8'h00, 32'h0000_0000, "ssd");
		rdc(8'h50, 32'h0000_0003, "status rst");
		// Two-LED channel at half, four-LED channel at full current.
		wr(8'h2A, 32'h0000_0003);
		wr(8'h2B, 32'h0000_0001);
		wr(8'h45, 32'h0000_0007);
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h2C, c * 2 + 1);
			settle;
			chk("div3", c + 1, div[8:6]);
		end
		chk("led ssd", 32'h0000_0000, led);
		rdc(8'h2A, 32'h0000_0003, "ch1");
		wr(8'h00, 32'h0000_0001);
		settle;
		chk("led run", 32'h0800_0007, led);
		chk("sleep run", 32'h0000_0000, sleep);
		chk("sel", 32'h0000_0031, ssel[5:0]);
		wr(8'h2B, 32'h0000_0000);
		settle;
		chk("led ch2", 32'h0800_0005, led);
		// A 1024 ns breath as 32 gamma steps into the unimplemented duty register must leave channels alone.
		for (int k = 0; k < 32; k++)
		begin
			wr(8'h05, host.ramp_step(k));
		end
		chk("led ramp", 32'h0800_0005, led);
		chk("sel ramp", 32'h0000_0031, ssel[5:0]);
		rdc(8'h05, 32'h0000_0000, "duty");
		pin_n <= 1'b0;
		settle;
		chk("led pin", 32'h0000_0000, led);
		chk("sleep pin", 32'h0000_0001, sleep);
		rdc(8'h00, 32'h0000_0001, "ssd pin");
		rdc(8'h50, 32'h0000_0005, "status pin");
		pin_n <= 1'b1;
		settle;
		chk("led back", 32'h0800_0005, led);
		rdc(8'h50, 32'h0000_0006, "status run");
		wr(8'h00, 32'h0000_0000);
		settle;
		chk("led off", 32'h0000_0000, led);
		chk("sel kept", 32'h0000_0031, ssel[5:0]);
		chk("sleep ssd", 32'h0000_0001, sleep);
		rdc(8'h45, 32'h0000_0007, "ch28");
		host.xfer(1'b1, 8'h45, 4'hE, 32'h0000_0000, q);
		rdc(8'h45, 32'h0000_0007, "lane");
		rdc(8'h60, 32'h0000_0000, "unmapped");
		end_of_test;
	end
endmodule // lcsc_ctrl_tb
`default_nettype wire
